// ==== rtl/ubeb_pkg.sv ====
// package: register map, field positions and codes of the bulk endpoint block
package ubeb_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_OUT_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IN_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUT_BCH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OUT_BCL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IN_BCH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IN_BCL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EP_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_APTR_SETUP = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_P1H = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_P1L = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_P2H = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_P2L = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_P1DAT = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_P2DAT = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_NAK_INTERRUPT_REQUEST = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_IRQMASK = 8'h3c;
  // endpoint configuration values
  localparam logic [7:0] CFG_OUT_BULK_DBL = 8'ha2;
  localparam logic [7:0] CFG_IN_BULK_DBL = 8'he2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int SKIP_BIT = 7;
  localparam int APTR_EN_BIT = 0;
  // endpoint status register bits
  localparam int ST_OUT_EMPTY = 0;
  localparam int ST_OUT_FULL = 1;
  localparam int ST_IN_EMPTY = 2;
  localparam int ST_IN_FULL = 3;
  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_PINGNAK = 0;
  localparam int IRQ_OUT_RX = 1;
  localparam int IRQ_IN_DONE = 2;
  // buffers
  localparam int OFS_W = 9;
  localparam int CNT_W = 10;
  localparam int MEM_W = 11;
  localparam logic [CNT_W-1:0] PKT_BYTES = 10'h200;
  localparam logic [1:0] BUF_CNT = 2'h2;
  localparam logic REGION_OUT = 1'b0;
  localparam logic REGION_IN = 1'b1;
  // link codes
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_PING = 2'h2;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RX = 4'b0010,
    S_TX = 4'b0100,
    S_TXWAIT = 4'b1000
  } ubeb_state_t;
endpackage

// ==== rtl/ubeb_axil_slave.sv ====
// axi4-lite slave handshake turning bus cycles into register strobes
`timescale 1ns/1ps
`default_nettype none
module ubeb_axil_slave
  import ubeb_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wrEn,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [7:0] wrData,
  input wire logic wrErr,
  output logic rdEn,
  input wire logic [31:0] rdValue,
  input wire logic rdErr
);
  logic awHeld;
  logic wHeld;
  logic lowLane;
  logic wrFire;

  assign wrFire = awHeld && wHeld && !bvalid;
  assign wrEn = wrFire && lowLane;
  assign rdEn = arvalid && arready;

  ////////////////////////////////////////////////////////////////////////////
  // write address and data taken in either order
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      wrAddr <= '0;
      wrData <= '0;
      lowLane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awready <= 1'b0;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wready <= 1'b0;
        wrData <= wdata[7:0];
        lowLane <= wstrb[0];
      end
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel, data captured at the address handshake
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rdEn) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdValue;
      rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ubeb_irq.sv ====
// sticky event status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module ubeb_irq
  import ubeb_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [IRQ_W-1:0] setVec,
  input wire logic [IRQ_W-1:0] clrVec,
  input wire logic maskWr,
  input wire logic [IRQ_W-1:0] maskData,
  output logic [IRQ_W-1:0] status,
  output logic [IRQ_W-1:0] mask,
  output logic irq
);
  logic [IRQ_W-1:0] next_status;
  logic [IRQ_W-1:0] next_mask;

  // set wins over a clear in the same cycle
  assign next_status = (status & ~clrVec) | setVec;
  assign next_mask = maskWr ? maskData : mask;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ubeb_top.sv ====
// top: double-buffered bulk out/in endpoint pair with register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - an out endpoint holds at most two received packets, one per buffer
// - with both out buffers occupied, further out packets get a nak
// - refusing an out transfer for lack of space raises its ping-nak event
// - rearming a full out endpoint frees one buffer for the retried packet
// - low byte count write with skip bit arms, releasing one buffer
// - out empty status flag set while no received packet is held
// - in full status flag set while all in buffers await the host
// - out byte count registers show bytes received in current buffer
// - writing in count high then low commits that many bytes to host
// - auto-pointer setup bit zero enables auto-incrementing pointers
// - each data port access moves one byte and advances its pointer
// - config 0xa2 selects bulk out, 0xe2 bulk in, both double-buffered
// - each buffer holds a 512-byte packet; in returns looped bytes
// - ping answered nak while no out buffer free, ack once free
// - writing one to the nak interrupt bit clears pending ping-nak
module ubeb_top
  import ubeb_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tokValid,
  input wire logic [1:0] tokKind,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEnd,
  input wire logic rxErr,
  input wire logic txReady,
  input wire logic hostAck,
  output logic hsValid,
  output logic [1:0] hsCode,
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  output logic txZero,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0] wrData;
  logic rdEn;
  logic [31:0] rdValue;
  logic [7:0] outCfg;
  logic [7:0] inCfg;
  logic aptrEn;
  logic outEn;
  logic inEn;
  logic [7:0] mem [0:(1<<MEM_W)-1];
  logic [1:0] outHasData;
  logic [1:0] outCpuCnt;
  logic [1:0] next_outCpuCnt;
  logic outHead;
  logic outTail;
  logic outCur;
  logic [CNT_W-1:0] outCnt [0:1];
  logic [CNT_W-1:0] outCurCnt;
  logic outFree;
  logic outEmpty;
  logic [1:0] inFull;
  logic inHead;
  logic inTail;
  logic [CNT_W-1:0] inCnt [0:1];
  logic [7:0] inPendHigh;
  logic [15:0] ptr [0:1];
  logic [1:0] pWr;
  logic [1:0] pRd;
  logic [MEM_W-1:0] pIdx [0:1];
  ubeb_state_t state;
  ubeb_state_t next_state;
  logic [CNT_W-1:0] rxIdx;
  logic [CNT_W-1:0] txIdx;
  logic tokTaken;
  logic outTok;
  logic refuse;
  logic rxStart;
  logic pingAck;
  logic inTok;
  logic txStart;
  logic inNak;
  logic rxCommit;
  logic rxWr;
  logic txStep;
  logic inDone;
  logic armWr;
  logic armOk;
  logic commitWr;
  logic [IRQ_W-1:0] setVec;
  logic [IRQ_W-1:0] clrVec;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;

  ////////////////////////////////////////////////////////////////////////////
  // decoders
  function automatic logic [MEM_W-1:0] memIdx(input logic [15:0] p,
      input logic outB, input logic inB);
    logic inRegion;
    inRegion = p[OFS_W];
    memIdx = {inRegion, inRegion ? inB : outB, p[OFS_W-1:0]};
  endfunction

  function automatic logic regMapped(input logic [ADDR_W-1:0] a);
    regMapped = (a <= OFS_IRQMASK) && (a[1:0] == '0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and interrupt
  ubeb_axil_slave uBus (
    .mclk(mclk),
    .rst_n(rst_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrErr(!regMapped(wrAddr)),
    .rdEn(rdEn),
    .rdValue(rdValue),
    .rdErr(!regMapped(s_axi_araddr))
  );

  assign setVec[IRQ_PINGNAK] = refuse;
  assign setVec[IRQ_OUT_RX] = rxCommit;
  assign setVec[IRQ_IN_DONE] = inDone;
  // arming also clears a pending ping-nak
  always_comb begin
    clrVec = '0;
    if (wrEn && wrAddr == OFS_NAK_INTERRUPT_REQUEST)
      clrVec = wrData[IRQ_W-1:0];
    if (armWr)
      clrVec[IRQ_PINGNAK] = 1'b1;
  end

  ubeb_irq uIrq (
    .mclk(mclk),
    .rst_n(rst_n),
    .setVec(setVec),
    .clrVec(clrVec),
    .maskWr(wrEn && wrAddr == OFS_IRQMASK),
    .maskData(wrData[IRQ_W-1:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outCfg <= CFG_RESET;
      inCfg <= CFG_RESET;
      aptrEn <= 1'b0;
    end else if (wrEn) begin
      if (wrAddr == OFS_OUT_CFG)
        outCfg <= wrData;
      if (wrAddr == OFS_IN_CFG)
        inCfg <= wrData;
      if (wrAddr == OFS_APTR_SETUP)
        aptrEn <= wrData[APTR_EN_BIT];
    end
  end

  assign outEn = outCfg == CFG_OUT_BULK_DBL;
  assign inEn = inCfg == CFG_IN_BULK_DBL;

  ////////////////////////////////////////////////////////////////////////////
  // link event decode
  assign tokTaken = tokValid && (state == S_IDLE ||
      (state == S_TXWAIT && !hostAck));
  assign outTok = tokTaken && outEn && (tokKind == TOK_OUT ||
      tokKind == TOK_PING);
  assign outFree = outCpuCnt != BUF_CNT;
  assign refuse = outTok && !outFree;
  assign rxStart = outTok && outFree && tokKind == TOK_OUT;
  assign pingAck = outTok && outFree && tokKind == TOK_PING;
  assign inTok = tokTaken && inEn && tokKind == TOK_IN;
  assign txStart = inTok && inFull[inHead];
  assign inNak = inTok && !inFull[inHead];
  assign rxCommit = state == S_RX && rxEnd && !rxErr;
  assign rxWr = state == S_RX && rxValid && rxIdx < PKT_BYTES;
  assign txStep = state == S_TX && txValid && txReady;
  assign inDone = state == S_TXWAIT && hostAck;
  assign armWr = wrEn && wrAddr == OFS_OUT_BCL && wrData[SKIP_BIT];
  assign armOk = armWr && outCpuCnt != '0;
  assign commitWr = wrEn && wrAddr == OFS_IN_BCL && !inFull[inTail];

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (rxStart)
          next_state = S_RX;
        else if (txStart)
          next_state = S_TX;
      end
      S_RX: begin
        if (rxEnd)
          next_state = S_IDLE;
      end
      S_TX: begin
        if (txStep && txLast)
          next_state = S_TXWAIT;
      end
      S_TXWAIT: begin
        if (inDone)
          next_state = S_IDLE;
        else if (rxStart)
          next_state = S_RX;
        else if (txStart)
          next_state = S_TX;
        else if (tokTaken)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake answer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hsValid <= 1'b0;
      hsCode <= HS_ACK;
    end else begin
      hsValid <= refuse || pingAck || rxCommit || inNak;
      if (refuse || inNak)
        hsCode <= HS_NAK;
      else if (pingAck || rxCommit)
        hsCode <= HS_ACK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // out buffer ring
  assign next_outCpuCnt = 2'(outCpuCnt + 2'(rxCommit) - 2'(armOk));
  assign outCur = outHasData[outHead] ? outHead : ~outHead;
  assign outCurCnt = outHasData[outCur] ? outCnt[outCur] : '0;
  assign outEmpty = outHasData == '0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outHasData <= '0;
      outHead <= 1'b0;
      outTail <= 1'b0;
      outCpuCnt <= BUF_CNT;
      outCnt <= '{default: '0};
    end else begin
      if (rxCommit) begin
        outHasData[outTail] <= 1'b1;
        outCnt[outTail] <= rxIdx;
        outTail <= ~outTail;
      end
      if (armOk) begin
        outHasData[outHead] <= 1'b0;
        outHead <= ~outHead;
      end
      outCpuCnt <= next_outCpuCnt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      rxIdx <= '0;
    else if (rxStart)
      rxIdx <= '0;
    else if (rxWr)
      rxIdx <= CNT_W'(rxIdx + CNT_W'(1));
  end

  ////////////////////////////////////////////////////////////////////////////
  // in buffer ring
  always_ff @(posedge mclk) begin
    if (!rst_n)
      inPendHigh <= '0;
    else if (wrEn && wrAddr == OFS_IN_BCH)
      inPendHigh <= wrData;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      inFull <= '0;
      inHead <= 1'b0;
      inTail <= 1'b0;
      inCnt <= '{default: '0};
    end else begin
      if (commitWr) begin
        inFull[inTail] <= 1'b1;
        inCnt[inTail] <= CNT_W'({inPendHigh, wrData});
        inTail <= ~inTail;
      end
      if (inDone) begin
        inFull[inHead] <= 1'b0;
        inHead <= ~inHead;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit to host
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txValid <= 1'b0;
      txData <= '0;
      txLast <= 1'b0;
      txZero <= 1'b0;
      txIdx <= '0;
    end else if (txStart) begin
      txIdx <= '0;
      txValid <= 1'b1;
      txData <= mem[{REGION_IN, inHead, {OFS_W{1'b0}}}];
      txLast <= inCnt[inHead] <= CNT_W'(1);
      txZero <= inCnt[inHead] == '0;
    end else if (txStep) begin
      if (txLast) begin
        txValid <= 1'b0;
        txZero <= 1'b0;
      end else begin
        txIdx <= CNT_W'(txIdx + CNT_W'(1));
        txData <= mem[{REGION_IN, inHead,
            OFS_W'(txIdx + CNT_W'(1))}];
        txLast <= CNT_W'(txIdx + CNT_W'(2)) == inCnt[inHead];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto-pointers
  for (genvar g = 0; g < 2; g++) begin : gPtr
    localparam logic [ADDR_W-1:0] HI = (g == 0) ? OFS_P1H : OFS_P2H;
    localparam logic [ADDR_W-1:0] LO = (g == 0) ? OFS_P1L : OFS_P2L;
    localparam logic [ADDR_W-1:0] DAT = (g == 0) ? OFS_P1DAT : OFS_P2DAT;
    assign pWr[g] = wrEn && wrAddr == DAT;
    assign pRd[g] = rdEn && s_axi_araddr == DAT;
    assign pIdx[g] = memIdx(ptr[g], outCur, inTail);
    always_ff @(posedge mclk) begin
      if (!rst_n)
        ptr[g] <= '0;
      else if (wrEn && wrAddr == HI)
        ptr[g][15:8] <= wrData;
      else if (wrEn && wrAddr == LO)
        ptr[g][7:0] <= wrData;
      else if (aptrEn)
        ptr[g] <= 16'(ptr[g] + 16'(pWr[g]) + 16'(pRd[g]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // endpoint buffer memory
  always_ff @(posedge mclk) begin
    if (rxWr)
      mem[{REGION_OUT, outTail, rxIdx[OFS_W-1:0]}] <= rxData;
    for (int i = 0; i < 2; i++) begin
      if (pWr[i])
        mem[pIdx[i]] <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    rdValue = '0;
    case (s_axi_araddr)
      OFS_OUT_CFG: rdValue[7:0] = outCfg;
      OFS_IN_CFG: rdValue[7:0] = inCfg;
      OFS_OUT_BCH: rdValue[7:0] = 8'(outCurCnt >> 8);
      OFS_OUT_BCL: rdValue[7:0] = outCurCnt[7:0];
      OFS_IN_BCH: rdValue[7:0] = inPendHigh;
      OFS_IN_BCL: rdValue[7:0] = inCnt[inHead][7:0];
      OFS_EP_STAT: begin
        rdValue[ST_OUT_EMPTY] = outEmpty;
        rdValue[ST_OUT_FULL] = !outFree;
        rdValue[ST_IN_EMPTY] = inFull == '0;
        rdValue[ST_IN_FULL] = &inFull;
      end
      OFS_APTR_SETUP: rdValue[APTR_EN_BIT] = aptrEn;
      OFS_P1H: rdValue[7:0] = ptr[0][15:8];
      OFS_P1L: rdValue[7:0] = ptr[0][7:0];
      OFS_P2H: rdValue[7:0] = ptr[1][15:8];
      OFS_P2L: rdValue[7:0] = ptr[1][7:0];
      OFS_P1DAT: rdValue[7:0] = mem[pIdx[0]];
      OFS_P2DAT: rdValue[7:0] = mem[pIdx[1]];
      OFS_NAK_INTERRUPT_REQUEST: rdValue[IRQ_W-1:0] = irqStatus;
      OFS_IRQMASK: rdValue[IRQ_W-1:0] = irqMask;
      default: rdValue = '0;
    endcase
  end
endmodule
`default_nettype wire

// ==== verif/ubeb_top_props.sv ====
// checker: port properties of the bulk endpoint block
`timescale 1ns/1ps
`default_nettype none
module ubeb_top_props
  import ubeb_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tokValid,
  input wire logic [1:0] tokKind,
  input wire logic rxEnd,
  input wire logic txReady,
  input wire logic hsValid,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  input wire logic txZero
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_hs_cause:
    assert property (hsValid |-> $past(tokValid) || $past(rxEnd))
    else $error("handshake without cause");
  a_tx_start:
    assert property ($rose(txValid) |->
      $past(tokValid) && $past(tokKind) == TOK_IN)
    else $error("in data without token");
  a_tx_hold:
    assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("in byte not held");
  a_tx_end:
    assert property (txValid && txReady && txLast |=> !txValid)
    else $error("in data past last");
  a_zero_last:
    assert property (txValid && txZero |-> txLast)
    else $error("zero packet not last");
  a_r_follow:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ar_block:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  cover property (hsValid);
  cover property (txValid && txReady && txLast);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ==== verif/ubeb_host_model.sv ====
// host model: bulk out, in and ping transactions
`timescale 1ns/1ps
`default_nettype none
module ubeb_host_model
  import ubeb_pkg::*;
(
  input wire logic mclk,
  output logic tokValid,
  output logic [1:0] tokKind,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxEnd,
  output logic rxErr,
  output logic txReady,
  output logic hostAck,
  input wire logic hsValid,
  input wire logic [1:0] hsCode,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast
);
  logic [7:0] inBuf [0:511];
  int inCnt;
  initial begin
    tokValid = 1'b0;
    tokKind = 2'h0;
    rxValid = 1'b0;
    rxData = 8'h00;
    rxEnd = 1'b0;
    rxErr = 1'b0;
    txReady = 1'b0;
    hostAck = 1'b0;
  end
  ////////////////////////////////////////
  // handshake code, 2'h3 when none came
  task automatic hs_wait(output logic [1:0] hs);
    hs = 2'h3;
    repeat (3) begin
      @(posedge mclk);
      if (hsValid) hs = hsCode;
    end
  endtask
  task automatic token(input logic [1:0] k, output logic [1:0] hs);
    @(posedge mclk);
    tokValid <= 1'b1;
    tokKind <= k;
    @(posedge mclk);
    tokValid <= 1'b0;
    hs_wait(hs);
  endtask
  // retried after a nak by the caller
  task automatic out_pkt(input int n, input logic [7:0] b,
    output logic [1:0] hs);
    token(TOK_OUT, hs);
    if (hs === HS_NAK) return;
    for (int i = 0; i < n; i++) begin
      rxValid <= 1'b1;
      rxData <= b + 8'(i);
      @(posedge mclk);
    end
    rxValid <= 1'b0;
    rxData <= ~rxData;
    rxEnd <= 1'b1;
    @(posedge mclk);
    rxEnd <= 1'b0;
    hs_wait(hs);
  endtask
  // slow drops ready every other cycle; ack frees the buffer
  task automatic in_pkt(input logic slow, input logic ack,
    output logic [1:0] hs);
    inCnt = 0;
    token(TOK_IN, hs);
    if (hs !== 2'h3) return;
    txReady <= 1'b1;
    repeat (2000) begin
      @(posedge mclk);
      if (txValid && txReady) begin
        inBuf[inCnt] = txData;
        inCnt++;
        if (txLast) break;
      end
      txReady <= slow ? ~txReady : 1'b1;
    end
    txReady <= 1'b0;
    hostAck <= ack;
    @(posedge mclk);
    hostAck <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_ubeb_top.sv ====
// testbench: registers, ping-nak and loopback through the block
`timescale 1ns/1ps
`default_nettype none
module tb_ubeb_top
  import ubeb_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, tokKind, hsCode;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tokValid, rxValid, rxEnd, rxErr, txReady, hostAck;
  logic hsValid, txValid, txLast, txZero, irq;
  logic [7:0] rxData, txData;
  int fails = 0, checksDone = 0;
  ubeb_top dut_u (.*);
  ubeb_host_model host_u (.*);
  initial forever #2.5 mclk = ~mclk;
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    checksDone++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    forever begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'h3;
    forever begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r === RESP_OKAY, "write refused");
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, string m);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d === e && r === RESP_OKAY, m);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    logic [1:0] hs, r;
    logic [7:0] d;
    rc(OFS_EP_STAT, 8'h07, "status at reset");
    host_u.token(TOK_PING, hs);
    chk(hs === 2'h3, "disabled ping answered");
    wr(8'h40, 8'h00, r);
    chk(r === RESP_SLVERR, "unmapped write");
    rd(8'h44, d, r);
    chk(r === RESP_SLVERR, "unmapped read");
    w(OFS_OUT_CFG, CFG_OUT_BULK_DBL);
    w(OFS_IN_CFG, CFG_IN_BULK_DBL);
    rc(OFS_IN_CFG, CFG_IN_BULK_DBL, "in cfg");
  endtask
  task automatic t_arm();
    logic [1:0] hs;
    w(OFS_IRQMASK, 8'h01);
    host_u.out_pkt(1, 8'h00, hs);
    chk(hs === HS_NAK, "unarmed out taken");
    repeat (2) @(posedge mclk);
    chk(irq === 1'b1, "no ping-nak irq");
    w(OFS_NAK_INTERRUPT_REQUEST, 8'h01);
    repeat (2) @(posedge mclk);
    chk(irq === 1'b0, "irq not cleared");
    w(OFS_OUT_BCL, 8'h80);
    w(OFS_OUT_BCL, 8'h80);
  endtask
  task automatic t_fill();
    logic [1:0] hs;
    host_u.out_pkt(512, 8'h10, hs);
    chk(hs === HS_ACK, "full packet");
    rc(OFS_OUT_BCH, 8'h02, "count high");
    rc(OFS_OUT_BCL, 8'h00, "count low");
    host_u.out_pkt(4, 8'h40, hs);
    chk(hs === HS_ACK, "second packet");
    rc(OFS_EP_STAT, 8'h06, "out held");
    host_u.out_pkt(4, 8'h60, hs);
    chk(hs === HS_NAK, "third packet taken");
    host_u.token(TOK_PING, hs);
    chk(hs === HS_NAK, "ping when full");
    rc(OFS_NAK_INTERRUPT_REQUEST, 8'h03, "irq status");
    w(OFS_OUT_BCL, 8'h80);
    host_u.token(TOK_PING, hs);
    chk(hs === HS_ACK, "ping after rearm");
    host_u.out_pkt(3, 8'h80, hs);
    chk(hs === HS_ACK, "retry refused");
    rc(OFS_OUT_BCL, 8'h04, "oldest count");
  endtask
  task automatic t_loop();
    logic [1:0] hs, r;
    logic [7:0] d;
    w(OFS_APTR_SETUP, 8'h01);
    w(OFS_P1H, 8'h00);
    w(OFS_P1L, 8'h00);
    w(OFS_P2H, 8'h02);
    w(OFS_P2L, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(OFS_P1DAT, d, r);
      chk(d === 8'h40 + 8'(i), "pointer byte");
      w(OFS_P2DAT, d);
    end
    w(OFS_IN_BCH, 8'h00);
    w(OFS_IN_BCL, 8'h04);
    w(OFS_P2L, 8'h00);
    for (int i = 0; i < 2; i++) begin
      w(OFS_P2DAT, 8'hc0 + 8'(i));
    end
    w(OFS_IN_BCH, 8'h00);
    w(OFS_IN_BCL, 8'h02);
    rc(OFS_EP_STAT, 8'h0a, "in full");
    host_u.in_pkt(1'b1, 1'b1, hs);
    chk(host_u.inCnt == 4, "in length");
    for (int i = 0; i < 4; i++) begin
      chk(host_u.inBuf[i] === 8'h40 + 8'(i), "looped byte");
    end
    rc(OFS_EP_STAT, 8'h02, "in freed");
    host_u.in_pkt(1'b0, 1'b1, hs);
    chk(host_u.inCnt == 2, "second in length");
    chk(host_u.inBuf[1] === 8'hc1, "second looped byte");
    host_u.in_pkt(1'b0, 1'b0, hs);
    chk(hs === HS_NAK, "empty in answered");
  endtask
  task automatic end_sim();
    if (fails == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_arm();
    t_fill();
    t_loop();
    end_sim();
  end
  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule
bind ubeb_top ubeb_top_props chk_u (.*);
`default_nettype wire
